// *** src/csc_pkg.sv ***
// Shared constants and types for the configuration sequencer and its controller.
package csc_pkg;
  localparam int CLK_MHZ = 40;
  // Minimum reconfiguration pulse in ns; the figure is a neutral default.
  localparam int RECONFIG_PULSE_MIN_NS = 500;
  localparam int RECONFIG_PULSE_CYC =
    (RECONFIG_PULSE_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int POR_DELAY_NS = 200;
  localparam int POR_DELAY_CYC = (POR_DELAY_NS * CLK_MHZ + 999) / 1000;
  localparam int INIT_CYC = 16;
  localparam int FLASH_AW = 10;
  localparam int CELL_AW = 10;
  localparam int DW = 16;
  localparam int CRC_W = 32;
  // Check pass time at divisor 2 in microseconds.
  localparam int CHECK_BASE_US = 2000;
  localparam int CHECK_BASE_CYC = CHECK_BASE_US * CLK_MHZ;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  // Compressed word layout: bit 15 marks a run; bits 14:8 count, 7:0 value.
  localparam int RUN_BIT = 15;
  localparam int RUN_CNT_HI = 14;
  localparam int RUN_CNT_LO = 8;
  typedef enum logic [2:0] {
    CSC_RESET = 3'b000,
    CSC_CONFIG = 3'b001,
    CSC_INIT = 3'b011,
    CSC_USER = 3'b010,
    CSC_ERROR = 3'b110
  } csc_state_e;
endpackage

// *** src/csc_link_if.sv ***
// Pin-level link between the device sequencer and the system controller.
`timescale 1ns/10ps
interface csc_link_if;
  logic reconfig_request_n;
  logic status_dev_oe;
  logic status_host_oe;
  logic done_dev_oe;
  logic crc_error;
  logic config_status_n;
  logic config_done_line;
  // Open-drain lines resolve low whenever any party drives them.
  assign config_status_n = ~(status_dev_oe | status_host_oe);
  assign config_done_line = ~done_dev_oe;
  modport device (
    input reconfig_request_n,
    input config_status_n,
    input config_done_line,
    output status_dev_oe,
    output done_dev_oe,
    output crc_error
  );
  modport host (
    output reconfig_request_n,
    output status_host_oe,
    input config_status_n,
    input config_done_line,
    input crc_error
  );
endinterface

// *** src/csc_decomp.sv ***
// Run-length expander feeding configuration cells while flash is read.
`timescale 1ns/10ps
module csc_decomp (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic compressed,
  input wire logic [15:0] flash_word,
  output logic need_word,
  output logic out_valid,
  output logic [7:0] out_byte
);
  logic [6:0] run_q, run_d;
  logic [7:0] val_q, val_d;
  logic hi_q, hi_d;
  logic [7:0] lo_q, lo_d;
  always_comb begin
    run_d = run_q;
    val_d = val_q;
    hi_d = hi_q;
    lo_d = lo_q;
    need_word = 1'b0;
    out_valid = 1'b0;
    out_byte = 8'h00;
    if (start) begin
      run_d = 7'h00;
      hi_d = 1'b0;
    end else if (run_q != 7'h00) begin
      out_valid = 1'b1;
      out_byte = val_q;
      run_d = run_q - 7'h01;
    end else if (hi_q) begin
      out_valid = 1'b1;
      out_byte = lo_q;
      hi_d = 1'b0;
    end else if (compressed &&
                 flash_word[csc_pkg::RUN_BIT]) begin
      need_word = 1'b1;
      out_valid = 1'b1;
      out_byte = flash_word[7:0];
      val_d = flash_word[7:0];
      run_d = flash_word[csc_pkg::RUN_CNT_HI:csc_pkg::RUN_CNT_LO];
    end else begin
      need_word = 1'b1;
      out_valid = 1'b1;
      out_byte = flash_word[15:8];
      lo_d = flash_word[7:0];
      hi_d = 1'b1;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      run_q <= 7'h00;
      val_q <= 8'h00;
      hi_q <= 1'b0;
      lo_q <= 8'h00;
    end else begin
      run_q <= run_d;
      val_q <= val_d;
      hi_q <= hi_d;
      lo_q <= lo_d;
    end
  end
endmodule

// *** src/csc_device.sv ***
// Device end: configuration sequencer with integrity check.
// Function
// - Controller pulses reconfiguration low at least minimum.
// - Request low pulls status and done low.
// - Reconfiguration: I/O weak pull-up or tri-state.
// - Controller pulses request after integrity error; csc_host pulses only on a write of bit 0 at offset 0.
// - Reconfiguration rewrites every configuration cell.
// - Compressed stream expanded on the fly.
// - Short reset delay before configuration stage.
// - Configuration copies flash into cell memory.
// - Auto-restart retries configuration after error.
// - Without auto-restart, controller watches status line.
// - Without auto-restart, controller pulses request.
// - Initialization starts after done line high.
// - Initialization runs on internal oscillator cycles.
// - After initialization enter user mode.
// - Dual-purpose pins stay configuration pins before user.
// - In user mode pins follow selected option.
// - Pass time scales as base times n/2.
// - Integrity check starts automatically in user mode.
// - Error flag holds until a clean pass.
// - Error flag is nonzero 32-bit signature.
//
// Implementation choices: the address-and-strobe port and the address map.
`timescale 1ns/10ps
module csc_device (
  input wire logic clk,
  input wire logic rst,
  csc_link_if.device link,
  input wire logic auto_restart,
  input wire logic compressed,
  input wire logic io_pullup_sel,
  input wire logic dual_pin_user,
  input wire logic check_enable,
  input wire logic [3:0] check_div,
  input wire logic [15:0] flash_rdata,
  input wire logic flash_error,
  input wire logic [31:0] crc_stored,
  input wire logic [31:0] crc_computed,
  output logic [9:0] flash_addr,
  output logic cell_we,
  output logic [9:0] cell_addr,
  output logic [7:0] cell_wdata,
  output logic io_weak_pullup,
  output logic io_tristate,
  output logic user_release,
  output logic dual_pin_is_user
);
  logic req_s1_q, req_s2_q;
  csc_pkg::csc_state_e st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [9:0] faddr_q, faddr_d;
  logic [9:0] caddr_q, caddr_d;
  logic we_q, we_d;
  logic [7:0] wd_q, wd_d;
  logic [31:0] pass_q, pass_d;
  logic [31:0] sig_q, sig_d;
  logic stat_oe_q, stat_oe_d;
  logic done_oe_q, done_oe_d;
  logic crc_q, crc_d;
  logic pu_q, pu_d, ts_q, ts_d, rel_q, rel_d, dp_q, dp_d;
  logic dc_start, need_word, dc_valid;
  logic [7:0] dc_byte;
  logic [31:0] pass_len;

  csc_decomp u_decomp (
    .clk(clk),
    .rst(rst),
    .start(dc_start),
    .compressed(compressed),
    .flash_word(flash_rdata),
    .need_word(need_word),
    .out_valid(dc_valid),
    .out_byte(dc_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // The request is synchronised before the sequencer looks at it.
  always_ff @(posedge clk) begin
    if (rst) begin
      req_s1_q <= 1'b1;
      req_s2_q <= 1'b1;
    end else begin
      req_s1_q <= link.reconfig_request_n;
      req_s2_q <= req_s1_q;
    end
  end

  // Divisor 2 gives the base time, so n scales it by n/2.
  assign pass_len = (32'(csc_pkg::CHECK_BASE_CYC) >> 1) *
    {28'h0000000, check_div};

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    st_d = st_q;
    cnt_d = cnt_q;
    faddr_d = faddr_q;
    caddr_d = caddr_q;
    we_d = 1'b0;
    wd_d = wd_q;
    pass_d = pass_q;
    sig_d = sig_q;
    crc_d = crc_q;
    stat_oe_d = 1'b1;
    done_oe_d = 1'b1;
    pu_d = io_pullup_sel;
    ts_d = ~io_pullup_sel;
    rel_d = 1'b0;
    dp_d = 1'b0;
    dc_start = 1'b0;
    if (!req_s2_q) begin
      // Holding the request low keeps the state, count, signature and flag in reset.
      st_d = csc_pkg::CSC_RESET;
      cnt_d = 16'h0000;
      crc_d = 1'b0;
      sig_d = 32'h00000000;
      dc_start = 1'b1;
    end else begin
      case (st_q)
        csc_pkg::CSC_RESET: begin
          dc_start = 1'b1;
          faddr_d = 10'h000;
          caddr_d = 10'h000;
          if (cnt_q >= 16'(csc_pkg::POR_DELAY_CYC)) begin
            st_d = csc_pkg::CSC_CONFIG;
            cnt_d = 16'h0000;
          end else begin
            cnt_d = cnt_q + csc_pkg::CNT_ONE;
          end
        end
        csc_pkg::CSC_CONFIG: begin
          stat_oe_d = 1'b0;
          if (flash_error) begin
            st_d = csc_pkg::CSC_ERROR;
          end else if (dc_valid) begin
            we_d = 1'b1;
            wd_d = dc_byte;
            caddr_d = caddr_q + 10'h001;
            if (need_word) begin
              faddr_d = faddr_q + 10'h001;
            end
            if (caddr_q == 10'h3ff) begin
              st_d = csc_pkg::CSC_INIT;
              done_oe_d = 1'b0;
              cnt_d = 16'h0000;
            end
          end
        end
        csc_pkg::CSC_INIT: begin
          stat_oe_d = 1'b0;
          done_oe_d = 1'b0;
          // Only counted once the done line reads high.
          if (link.config_done_line) begin
            if (cnt_q == 16'(csc_pkg::INIT_CYC - 1)) begin
              st_d = csc_pkg::CSC_USER;
              pass_d = 32'h00000000;
            end else begin
              cnt_d = cnt_q + csc_pkg::CNT_ONE;
            end
          end
        end
        csc_pkg::CSC_USER: begin
          stat_oe_d = 1'b0;
          done_oe_d = 1'b0;
          pu_d = 1'b0;
          ts_d = 1'b0;
          rel_d = 1'b1;
          dp_d = dual_pin_user;
          if (check_enable) begin
            if (pass_q + 32'h00000001 >= pass_len) begin
              pass_d = 32'h00000000;
              sig_d = crc_stored ^ crc_computed;
              // Flag follows the signature; it only moves at pass end or while the request is held low.
              crc_d = sig_d != 32'h00000000;
            end else begin
              pass_d = pass_q + 32'h00000001;
            end
          end
        end
        csc_pkg::CSC_ERROR: begin
          if (auto_restart) begin
            st_d = csc_pkg::CSC_RESET;
            cnt_d = 16'h0000;
          end
        end
        default: begin
          st_d = csc_pkg::CSC_RESET;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q <= csc_pkg::CSC_RESET;
      cnt_q <= 16'h0000;
      faddr_q <= 10'h000;
      caddr_q <= 10'h000;
      we_q <= 1'b0;
      wd_q <= 8'h00;
      pass_q <= 32'h00000000;
      sig_q <= 32'h00000000;
      crc_q <= 1'b0;
      stat_oe_q <= 1'b1;
      done_oe_q <= 1'b1;
      pu_q <= 1'b0;
      ts_q <= 1'b1;
      rel_q <= 1'b0;
      dp_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      faddr_q <= faddr_d;
      caddr_q <= caddr_d;
      we_q <= we_d;
      wd_q <= wd_d;
      pass_q <= pass_d;
      sig_q <= sig_d;
      crc_q <= crc_d;
      stat_oe_q <= stat_oe_d;
      done_oe_q <= done_oe_d;
      pu_q <= pu_d;
      ts_q <= ts_d;
      rel_q <= rel_d;
      dp_q <= dp_d;
    end
  end

  // Write data trails the cell address by one cycle, so register the address too.
  logic [9:0] wa_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      wa_q <= 10'h000;
    end else begin
      wa_q <= caddr_q;
    end
  end

  assign link.status_dev_oe = stat_oe_q;
  assign link.done_dev_oe = done_oe_q;
  assign link.crc_error = crc_q;
  assign flash_addr = faddr_q;
  assign cell_we = we_q;
  assign cell_addr = wa_q;
  assign cell_wdata = wd_q;
  assign io_weak_pullup = pu_q;
  assign io_tristate = ts_q;
  assign user_release = rel_q;
  assign dual_pin_is_user = dp_q;
endmodule

// *** src/csc_host.sv ***
// System controller end: drives reconfiguration and watches status lines.
`timescale 1ns/10ps
module csc_host (
  input wire logic clk,
  input wire logic rst,
  csc_link_if.host link,
  input wire logic [1:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata
);
  logic [15:0] pulse_q, pulse_d;
  logic req_n_q, req_n_d;
  logic [7:0] rdata_q, rdata_d;
  always_comb begin
    pulse_d = pulse_q;
    req_n_d = 1'b1;
    rdata_d = 8'h00;
    // Writing 1 to bit 0 at offset 0 starts a reconfiguration pulse.
    // The request rises on the edge that empties the count, so it stays low
    // for as many cycles as the count loaded, one more than the minimum width.
    if (wr && addr == 2'h0 && wdata[0]) begin
      pulse_d = 16'(csc_pkg::RECONFIG_PULSE_CYC + 1);
    end else if (pulse_q != 16'h0000) begin
      pulse_d = pulse_q - csc_pkg::CNT_ONE;
    end
    if (pulse_d != 16'h0000) begin
      req_n_d = 1'b0;
    end
    if (rd) begin
      rdata_d = {4'h0, pulse_q != 16'h0000, link.crc_error,
                 link.config_done_line, link.config_status_n};
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      pulse_q <= 16'h0000;
      req_n_q <= 1'b1;
      rdata_q <= 8'h00;
    end else begin
      pulse_q <= pulse_d;
      req_n_q <= req_n_d;
      rdata_q <= rdata_d;
    end
  end
  assign link.reconfig_request_n = req_n_q;
  assign link.status_host_oe = 1'b0;
  assign rdata = rdata_q;
endmodule

// *** verification/csc_checker.sv ***
// Assertions on the link between the sequencer and its controller.
`timescale 1ns/10ps
module csc_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic reconfig_request_n,
  input wire logic status_dev_oe,
  input wire logic status_host_oe,
  input wire logic done_dev_oe,
  input wire logic crc_error,
  input wire logic config_status_n,
  input wire logic config_done_line
);
  localparam int PLO = csc_pkg::RECONFIG_PULSE_CYC;
  localparam int PHI = PLO + 4;
  logic [7:0] low_d;
  logic [7:0] low_q;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  // An 8-bit count is enough; the controller never holds 255 cycles.
  always_comb begin
    low_d = reconfig_request_n ? 8'h00 : low_q + 8'h01;
  end
  always_ff @(posedge clk) begin
    low_q <= rst ? 8'h00 : low_d;
  end
  ////////////////////////////////////////
  chk_pulse_min: assert property (
    $rose(reconfig_request_n) |-> low_q >= PLO)
    else $error("request pulse too short");
  chk_pulse_ends: assert property (
    $fell(reconfig_request_n) |-> ##[PLO:PHI] $rose(reconfig_request_n))
    else $error("request pulse did not end");
  chk_lines_low: assert property (
    !reconfig_request_n [*4] |-> status_dev_oe && done_dev_oe)
    else $error("device not pulling lines low");
  chk_wires_low: assert property (
    !reconfig_request_n [*4] |-> !config_status_n && !config_done_line)
    else $error("status wires not low");
  chk_reset_delay: assert property (
    $rose(reconfig_request_n) |-> status_dev_oe [*3])
    else $error("configuration began without delay");
  chk_done_order: assert property (
    $fell(done_dev_oe) |-> !status_dev_oe && !status_host_oe)
    else $error("done released while status low");
  chk_done_holds: assert property (
    $fell(done_dev_oe) |-> !done_dev_oe [*8])
    else $error("done line dropped early");
  chk_flag_user: assert property (
    crc_error |-> !done_dev_oe)
    else $error("integrity flag outside user mode");
endmodule

// *** verification/config_sequence_controller_test.sv ***
// Self-checking bench joining the sequencer to its controller.
`timescale 1ns/10ps
module config_sequence_controller_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ar = 1'b1, cmp = 1'b0, pull, dpu, cen = 1'b0, ferr = 1'b0;
  logic wr = 1'b0, rd = 1'b0, cwe, wpu, tri_o, urel, dpiu;
  logic [3:0] div = 4'h2;
  logic [1:0] addr = 2'h0;
  logic [7:0] wdata = 8'h00, cdata, rdata;
  logic [31:0] cst = 32'h0, ccm = 32'h0;
  logic [15:0] flash [1024];
  logic [9:0] faddr, caddr;
  logic [17:0] q[$];
  int seed = 85, n_errors = 0, checks = 0, cyc = 0, k, watch = 1;
  localparam int P = csc_pkg::CHECK_BASE_CYC * 1 / 2;
  csc_link_if csc_link_if_i ();
  csc_device csc_device_i (.clk(clk), .rst(rst), .link(csc_link_if_i.device),
    .auto_restart(ar), .compressed(cmp), .io_pullup_sel(pull),
    .dual_pin_user(dpu), .check_enable(cen), .check_div(div),
    .flash_rdata(flash[faddr]), .flash_error(ferr), .crc_stored(cst),
    .crc_computed(ccm), .flash_addr(faddr), .cell_we(cwe),
    .cell_addr(caddr), .cell_wdata(cdata), .io_weak_pullup(wpu),
    .io_tristate(tri_o), .user_release(urel), .dual_pin_is_user(dpiu));
  csc_host csc_host_i (.clk(clk), .rst(rst), .link(csc_link_if_i.host),
    .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
  csc_checker csc_checker_i (.clk(clk), .rst(rst),
    .reconfig_request_n(csc_link_if_i.reconfig_request_n),
    .status_dev_oe(csc_link_if_i.status_dev_oe),
    .status_host_oe(csc_link_if_i.status_host_oe),
    .done_dev_oe(csc_link_if_i.done_dev_oe),
    .crc_error(csc_link_if_i.crc_error),
    .config_status_n(csc_link_if_i.config_status_n),
    .config_done_line(csc_link_if_i.config_done_line));
  always #12.5 clk = ~clk;
  ////////////////////////////////////////
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wreg(logic [1:0] a);
    @(posedge clk);
    addr <= a;
    wdata <= 8'h01;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(logic [7:0] e);
    @(posedge clk);
    addr <= 2'h0;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    chk("host status", e, rdata);
  endtask
  task automatic wait_user();
    k = 0;
    while (urel !== 1'b1 && k < 4000) begin
      @(posedge clk);
      k++;
    end
    chk("user_release", 1, urel);
    chk("dual pin", dpu, dpiu);
  endtask
  task automatic wait_flag(logic v);
    k = 0;
    while (csc_link_if_i.crc_error !== v && k < P + 100) begin
      @(posedge clk);
      k++;
    end
  endtask
  // Run words of 128 copies fill the 1024 cells from eight flash words.
  task automatic fill();
    for (int i = 0; i < 8; i++) begin
      flash[i] = {1'b1, 7'h7f, 8'($random(seed))};
      for (int j = 0; j < 128; j++) begin
        q.push_back({10'(i * 128 + j), flash[i][7:0]});
      end
    end
  endtask
  task automatic mid();
    chk("tristate", !pull, tri_o);
    chk("pullup", pull, wpu);
    chk("dual early", 0, dpiu);
  endtask
  ////////////////////////////////////////
  always @(posedge clk) begin
    if (cwe === 1'b1 && watch == 1) begin
      if (q.size() == 0) chk("cell extra", 0, 1);
      else chk("cell", q.pop_front(), {caddr, cdata});
    end
    cyc++;
    if (cyc == 100000) begin
      n_errors++;
      conclude();
    end
  end
  initial begin
    pull = 1'($random(seed));
    dpu = 1'($random(seed));
    for (int i = 0; i < 1024; i++) flash[i] = 16'($random(seed));
    for (int i = 0; i < 512; i++) begin
      q.push_back({10'(2 * i), flash[i][15:8]});
      q.push_back({10'(2 * i + 1), flash[i][7:0]});
    end
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (12) @(posedge clk);
    mid();
    wait_user();
    chk("cells left", 0, q.size());
    rreg(8'h03);
    wreg(2'h1);
    repeat (5) @(posedge clk);
    chk("refused", 1, csc_link_if_i.reconfig_request_n);
    fill();
    cmp <= 1'b1;
    pull <= ~pull;
    dpu <= ~dpu;
    wreg(2'h0);
    repeat (4) @(posedge clk);
    rreg(8'h08);
    repeat (25) @(posedge clk);
    mid();
    wait_user();
    chk("cells left", 0, q.size());
    watch = 0;
    for (int a = 0; a < 2; a++) begin
      ar <= (a == 0);
      wreg(2'h0);
      repeat (60) @(posedge clk);
      ferr <= 1'b1;
      @(posedge clk);
      ferr <= 1'b0;
      if (a == 0) begin
        wait_user();
      end else begin
        repeat (600) @(posedge clk);
        chk("held", 0, {urel, csc_link_if_i.config_status_n});
        wreg(2'h0);
        repeat (25) @(posedge clk);
        wait_user();
      end
    end
    watch = 1;
    k = $random(seed);
    cen <= 1'b1;
    div <= 4'h1;
    cst <= 32'(k);
    ccm <= 32'(k) ^ 32'h1;
    fill();
    wreg(2'h0);
    repeat (25) @(posedge clk);
    wait_user();
    chk("cells left", 0, q.size());
    wait_flag(1'b1);
    chk("pass time", 1, k >= P - 8 && k <= P + 8);
    rreg(8'h07);
    @(posedge clk);
    ccm <= cst;
    wait_flag(1'b0);
    chk("flag hold", 1, k >= P - 12 && k <= P + 8);
    conclude();
  end
endmodule
